// [add8_flags.sv]
// 8-bit adder with carry, nibble carry, signed wrap and zero outputs
`timescale 1ns/10ps

module add8_flags
(
   input wire logic [7:0] a,
   input wire logic [7:0] b,
   input wire logic cin,
   output logic [7:0] sum,
   output logic cout,
   output logic nib_out,
   output logic wrap_out,
   output logic zero_out
);

   logic [4:0] low;
   logic [3:0] high;
   logic c6;

   always_comb
   begin
      low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      {c6, high[2:0]} = {1'b0, a[6:4]} + {1'b0, b[6:4]} + {3'h0, low[4]};
      {cout, high[3]} = {1'b0, a[7]} + {1'b0, b[7]} + {1'b0, c6};
      sum = {high, low[3:0]};
      nib_out = low[4];
      // signed wrap: carry into the sign bit differs from carry out of it
      wrap_out = c6 ^ cout;
      zero_out = (sum == 8'h00);
   end

endmodule : add8_flags

// [exec_core.sv]
// add, and and call execution datapath with register port and memory/stack side
//
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/10ps
`include "exec_regs.svh"

// Operation
// - add with carry, sum to working register
// - add with carry, sum to memory byte
// - plain add from memory into working register
// - add immediate into working register
// - plain add, sum written to memory
// - and from memory, only zero flag
// - and immediate, only zero flag
// - and into memory, only zero flag
// - call pushes pc plus one, loads target
// - call takes two instruction cycles
// - program counter change costs two cycles
module exec_core
   import exec_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [`REG_ADDR_W-1:0] reg_addr,
   input wire logic [`REG_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [`REG_DATA_W-1:0] reg_rdata,
   output logic [7:0] mem_addr,
   output logic mem_rd,
   input wire logic [7:0] mem_rdata,
   output logic mem_wr,
   output logic [7:0] mem_wdata,
   output logic stk_push,
   output logic [`PC_W-1:0] stk_data,
   output logic [`PC_W-1:0] pc_out
);

   exec_st_t st_r;
   exec_st_t st_nxt;

   logic [7:0] add_b;
   logic add_cin;
   logic [7:0] add_sum;
   logic add_c;
   logic add_nib;
   logic add_wrap;
   logic add_zero;
   logic [7:0] and_res;
   logic busy;

   function automatic logic uses_imm(input op_t op);
      uses_imm = (op == OP_ADD_IMM) || (op == OP_AND_IMM);
   endfunction : uses_imm

   function automatic logic needs_mem(input op_t op);
      needs_mem = !uses_imm(op) && (op != OP_CALL);
   endfunction : needs_mem

   function automatic logic carry_out(input logic [7:0] a, input logic [7:0] b, input logic cin);
      logic [8:0] s;
      s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      carry_out = s[8];
   endfunction : carry_out

   assign busy = (st_r.state != S_IDLE);

   // second operand: immediate field of operand register or the fetched memory byte
   always_comb
   begin
      add_b = uses_imm(st_r.op) ? st_r.operand[7:0] : mem_rdata;
      // old carry feeds the sum; the new one is only known after the add
      add_cin = ((st_r.op == OP_ADC_WREG) || (st_r.op == OP_ADC_MEM)) ? st_r.carry : 1'b0;
      and_res = st_r.wreg & add_b;
   end

   add8_flags u_add
   (
      .a(st_r.wreg),
      .b(add_b),
      .cin(add_cin),
      .sum(add_sum),
      .cout(add_c),
      .nib_out(add_nib),
      .wrap_out(add_wrap),
      .zero_out(add_zero)
   );

   always_comb
   begin
      st_nxt = st_r;
      st_nxt.mem_rd = 1'b0;
      st_nxt.mem_wr = 1'b0;
      st_nxt.stk_push = 1'b0;
      st_nxt.rdata = '0;

      if (reg_rd)
      begin
         case (reg_addr)
            `ADDR_WREG: st_nxt.rdata = {8'h00, st_r.wreg};
            `ADDR_FLAGS:
            begin
               st_nxt.rdata[`FLG_CARRY] = st_r.carry;
               st_nxt.rdata[`FLG_NIBBLE] = st_r.nibble;
               st_nxt.rdata[`FLG_ZERO] = st_r.zero;
               st_nxt.rdata[`FLG_WRAP] = st_r.wrap;
            end
            `ADDR_PC: st_nxt.rdata = {{(`REG_DATA_W-`PC_W){1'b0}}, st_r.pc};
            `ADDR_OPERAND: st_nxt.rdata = st_r.operand;
            `ADDR_STATUS:
            begin
               st_nxt.rdata[`STAT_BUSY] = busy;
               st_nxt.rdata[`STAT_CYC_MSB:`STAT_CYC_LSB] = st_r.last_cyc;
            end
            default: st_nxt.rdata = '0;
         endcase
      end

      unique case (st_r.state)
         S_IDLE:
         begin
            // writes land only between instructions, so an op never sees a half update
            if (reg_wr)
            begin
               case (reg_addr)
                  `ADDR_WREG: st_nxt.wreg = reg_wdata[7:0];
                  `ADDR_FLAGS:
                  begin
                     st_nxt.carry = reg_wdata[`FLG_CARRY];
                     st_nxt.nibble = reg_wdata[`FLG_NIBBLE];
                     st_nxt.zero = reg_wdata[`FLG_ZERO];
                     st_nxt.wrap = reg_wdata[`FLG_WRAP];
                  end
                  `ADDR_PC: st_nxt.pc = reg_wdata[`PC_W-1:0];
                  `ADDR_OPERAND: st_nxt.operand = reg_wdata;
                  `ADDR_CMD:
                  begin
                     // unknown op codes are dropped silently
                     if (reg_wdata[`CMD_OP_MSB:`CMD_OP_LSB] <= `OP_LAST)
                     begin
                        st_nxt.op = op_t'(reg_wdata[`CMD_OP_MSB:`CMD_OP_LSB]);
                        st_nxt.maddr = reg_wdata[`CMD_MADDR_MSB:`CMD_MADDR_LSB];
                        st_nxt.mem_rd = needs_mem(op_t'(reg_wdata[`CMD_OP_MSB:`CMD_OP_LSB]));
                        st_nxt.state = S_FETCH;
                     end
                  end
                  default: ;
               endcase
            end
         end
         S_FETCH:
         begin
            st_nxt.state = (st_r.op == OP_CALL) ? S_PUSH : S_EXEC;
         end
         S_EXEC:
         begin
            unique case (st_r.op)
               OP_ADC_WREG, OP_ADD_WREG, OP_ADD_IMM:
               begin
                  st_nxt.wreg = add_sum;
               end
               OP_ADC_MEM, OP_ADD_MEM:
               begin
                  st_nxt.mem_wr = 1'b1;
                  st_nxt.mem_wdata = add_sum;
               end
               OP_AND_WREG, OP_AND_IMM:
               begin
                  st_nxt.wreg = and_res;
               end
               OP_AND_MEM:
               begin
                  st_nxt.mem_wr = 1'b1;
                  st_nxt.mem_wdata = and_res;
               end
               OP_CALL: ;
            endcase
            if ((st_r.op == OP_AND_WREG) || (st_r.op == OP_AND_IMM) || (st_r.op == OP_AND_MEM))
            begin
               st_nxt.zero = (and_res == 8'h00);
            end
            else
            begin
               st_nxt.carry = add_c;
               st_nxt.nibble = add_nib;
               st_nxt.wrap = add_wrap;
               st_nxt.zero = add_zero;
            end
            st_nxt.pc = st_r.pc + `PC_STEP;
            st_nxt.last_cyc = `SHORT_CYCLES;
            st_nxt.state = S_IDLE;
         end
         S_PUSH:
         begin
            st_nxt.stk_push = 1'b1;
            st_nxt.stk_data = st_r.pc + `PC_STEP;
            st_nxt.state = S_FILL;
         end
         S_FILL:
         begin
            // extra half of the second instruction cycle
            st_nxt.state = S_LOAD;
         end
         S_LOAD:
         begin
            st_nxt.pc = st_r.operand[`PC_W-1:0];
            st_nxt.last_cyc = `CALL_CYCLES;
            st_nxt.state = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         st_r <= '0;
         st_r.wreg <= `WREG_RST;
         st_r.pc <= `PC_RST;
         st_r.operand <= `OPERAND_RST;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign reg_rdata = st_r.rdata;
   assign mem_addr = st_r.maddr;
   assign mem_rd = st_r.mem_rd;
   assign mem_wr = st_r.mem_wr;
   assign mem_wdata = st_r.mem_wdata;
   assign stk_push = st_r.stk_push;
   assign stk_data = st_r.stk_data;
   assign pc_out = st_r.pc;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (sys_rst);

   a_adc_wreg_sum: assert property (
      (st_r.state == S_EXEC && st_r.op == OP_ADC_WREG)
      |=> st_r.wreg == 8'($past(st_r.wreg) + $past(mem_rdata) + {7'h00, $past(st_r.carry)}))
      else $error("adc to working register gave wrong sum");

   a_adc_mem_write: assert property (
      (st_r.state == S_EXEC && st_r.op == OP_ADC_MEM)
      |=> mem_wr && st_r.wreg == $past(st_r.wreg)
      && mem_wdata == 8'($past(st_r.wreg) + $past(mem_rdata) + {7'h00, $past(st_r.carry)}))
      else $error("adc to memory wrote wrong byte");

   a_add_wreg_carry: assert property (
      (st_r.state == S_EXEC && st_r.op == OP_ADD_WREG)
      |=> st_r.wreg == 8'($past(st_r.wreg) + $past(mem_rdata))
      && st_r.carry == carry_out($past(st_r.wreg), $past(mem_rdata), 1'b0))
      else $error("add from memory wrong sum or carry");

   a_add_imm_sum: assert property (
      (st_r.state == S_EXEC && st_r.op == OP_ADD_IMM)
      |=> st_r.wreg == 8'($past(st_r.wreg) + $past(st_r.operand[7:0])) && !mem_wr)
      else $error("add immediate wrong sum");

   a_add_into_mem: assert property (
      (st_r.state == S_EXEC && st_r.op == OP_ADD_MEM)
      |=> mem_wr && mem_wdata == 8'($past(st_r.wreg) + $past(mem_rdata))
      && st_r.zero == (mem_wdata == 8'h00))
      else $error("add into memory wrong byte or zero");

   a_and_keeps_flags: assert property (
      (st_r.state == S_EXEC && st_r.op == OP_AND_WREG)
      |=> $stable(st_r.carry) && $stable(st_r.nibble) && $stable(st_r.wrap)
      && st_r.wreg == ($past(st_r.wreg) & $past(mem_rdata)))
      else $error("and from memory touched other flags");

   a_and_imm_zero: assert property (
      (st_r.state == S_EXEC && st_r.op == OP_AND_IMM)
      |=> st_r.zero == (($past(st_r.wreg) & $past(st_r.operand[7:0])) == 8'h00)
      && $stable(st_r.carry))
      else $error("and immediate zero flag wrong");

   a_and_into_mem: assert property (
      (st_r.state == S_EXEC && st_r.op == OP_AND_MEM)
      |=> mem_wr && mem_wdata == ($past(st_r.wreg) & $past(mem_rdata)) && $stable(st_r.wrap))
      else $error("and into memory wrong byte");

   a_call_push_ret: assert property (
      (st_r.state == S_PUSH)
      |=> stk_push && stk_data == $past(st_r.pc) + `PC_STEP ##1 !stk_push)
      else $error("call pushed wrong return address");

   a_call_load_pc: assert property (
      (st_r.state == S_FETCH && st_r.op == OP_CALL)
      |-> ##4 pc_out == $past(st_r.operand[`PC_W-1:0], 1))
      else $error("call did not load target");

   a_call_two_cycles: assert property (
      (st_r.state == S_FETCH && st_r.op == OP_CALL)
      |-> busy [*4] ##1 (!busy && st_r.last_cyc == `CALL_CYCLES))
      else $error("call length not two instruction cycles");

   a_adc_old_carry: assert property (
      (st_r.state == S_EXEC && st_r.op == OP_ADC_WREG)
      |=> st_r.carry == carry_out($past(st_r.wreg), $past(mem_rdata), $past(st_r.carry)))
      else $error("adc carry not from old carry");

endmodule : exec_core

// [exec_mem_model.sv]
// behavioural data memory and return stack facing the datapath
`timescale 1ns/10ps
`include "exec_regs.svh"

module exec_mem_model
(
   input wire logic mclk,
   input wire logic [7:0] mem_addr,
   input wire logic mem_rd,
   output logic [7:0] mem_rdata,
   input wire logic mem_wr,
   input wire logic [7:0] mem_wdata,
   input wire logic stk_push,
   input wire logic [`PC_W-1:0] stk_data
);
   logic [7:0] mem [256];
   logic [`PC_W-1:0] stk_top;
   int push_cnt = 0;

   initial mem_rdata = 8'h00;

   always @(posedge mclk)
   begin
      // data valid only in the cycle after the read; scrambled otherwise
      if (mem_rd)
         mem_rdata <= mem[mem_addr];
      else
         mem_rdata <= ~mem_rdata;
      if (mem_wr)
         mem[mem_addr] <= mem_wdata;
      if (stk_push)
      begin
         stk_top <= stk_data;
         push_cnt <= push_cnt + 1;
      end
   end
endmodule : exec_mem_model

// [exec_pkg.sv]
// types of the add/and/call datapath
`include "exec_regs.svh"

package exec_pkg;

   typedef enum logic [3:0] {
      OP_ADC_WREG,
      OP_ADC_MEM,
      OP_ADD_WREG,
      OP_ADD_IMM,
      OP_ADD_MEM,
      OP_AND_WREG,
      OP_AND_IMM,
      OP_AND_MEM,
      OP_CALL
   } op_t;

   typedef enum logic [2:0] {
      S_IDLE,
      S_FETCH,
      S_EXEC,
      S_PUSH,
      S_FILL,
      S_LOAD
   } state_t;

   typedef struct packed {
      state_t state;
      op_t op;
      logic [7:0] maddr;
      logic [7:0] wreg;
      logic carry;
      logic nibble;
      logic zero;
      logic wrap;
      logic [`PC_W-1:0] pc;
      logic [`REG_DATA_W-1:0] operand;
      logic [7:0] last_cyc;
      logic mem_rd;
      logic mem_wr;
      logic [7:0] mem_wdata;
      logic stk_push;
      logic [`PC_W-1:0] stk_data;
      logic [`REG_DATA_W-1:0] rdata;
   } exec_st_t;

endpackage : exec_pkg

// [exec_regs.svh]
// register offsets, field positions, reset values and timing counts of the add/and/call datapath
`ifndef EXEC_REGS_SVH
`define EXEC_REGS_SVH

`define REG_ADDR_W 8
`define REG_DATA_W 16
`define PC_W 12

`define ADDR_WREG 8'h00
`define ADDR_FLAGS 8'h04
`define ADDR_PC 8'h08
`define ADDR_OPERAND 8'h0C
`define ADDR_CMD 8'h10
`define ADDR_STATUS 8'h14

`define FLG_CARRY 0
`define FLG_NIBBLE 1
`define FLG_ZERO 2
`define FLG_WRAP 3

`define CMD_OP_LSB 0
`define CMD_OP_MSB 3
`define CMD_MADDR_LSB 8
`define CMD_MADDR_MSB 15
`define STAT_BUSY 0
`define STAT_CYC_LSB 8
`define STAT_CYC_MSB 15

`define WREG_RST 8'h00
`define PC_RST 12'h000
`define OPERAND_RST 16'h0000

`define PC_STEP 12'h001
`define SHORT_CYCLES 8'h01
`define CALL_CYCLES 8'h02
`define OP_LAST 4'h8

`endif

// [tb_top.sv]
// self-checking bench of the add/and/call datapath
`timescale 1ns/10ps
`include "exec_regs.svh"

module tb_top
   import exec_pkg::*;
;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] reg_rdata;
   logic [7:0] mem_addr;
   logic mem_rd;
   logic [7:0] mem_rdata;
   logic mem_wr;
   logic [7:0] mem_wdata;
   logic stk_push;
   logic [`PC_W-1:0] stk_data;
   logic [`PC_W-1:0] pc_out;
   int error_cnt = 0;
   int total_checks = 0;

   always #4 mclk = ~mclk;

   exec_core u_dut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata), .mem_wr(mem_wr),
      .mem_wdata(mem_wdata), .stk_push(stk_push), .stk_data(stk_data), .pc_out(pc_out));

   exec_mem_model u_mem (.mclk(mclk), .mem_addr(mem_addr), .mem_rd(mem_rd),
      .mem_rdata(mem_rdata), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
      .stk_push(stk_push), .stk_data(stk_data));

   task automatic conclude;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : conclude

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      total_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   // gap cycle after each strobe keeps one assignment per signal per step
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      @(posedge mclk);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
      @(posedge mclk);
   endtask : rd

   task automatic wait_idle;
      logic [15:0] v;
      int n;
      v = 16'h0001;
      n = 0;
      while (v[0] !== 1'b0 && n < 20)
      begin
         rd(`ADDR_STATUS, v);
         n++;
      end
      chk({15'h0000, v[0]}, 16'h0000, "busy stuck");
   endtask : wait_idle

   function automatic logic [11:0] add_ref(input logic [7:0] a, input logic [7:0] b,
      input logic c);
      logic [8:0] s;
      logic [4:0] n;
      s = a + b + c;
      n = a[3:0] + b[3:0] + c;
      return {(a[7] == b[7]) && (s[7] != a[7]), s[7:0] == 8'h00, n[4], s[8], s[7:0]};
   endfunction : add_ref

   task automatic t_reset;
      logic [15:0] v;
      rd(`ADDR_WREG, v);
      chk(v, 16'h0000, "wreg reset");
      rd(`ADDR_FLAGS, v);
      chk(v, 16'h0000, "flags reset");
      rd(`ADDR_PC, v);
      chk(v, 16'h0000, "pc reset");
      rd(`ADDR_OPERAND, v);
      chk(v, 16'h0000, "operand reset");
      rd(8'h18, v);
      chk(v, 16'h0000, "unmapped read");
      wr(`ADDR_CMD, 16'h0009);
      rd(`ADDR_STATUS, v);
      chk(v & 16'h0001, 16'h0000, "bad op busy");
      rd(`ADDR_PC, v);
      chk(v, 16'h0000, "bad op pc");
   endtask : t_reset

   task automatic do_op(input op_t op, input logic [7:0] w, input logic [7:0] m,
      input logic [3:0] f);
      logic [15:0] v;
      logic [11:0] r;
      logic [7:0] res;
      logic [3:0] ef;
      logic imm;
      logic tomem;
      logic isand;
      imm = op inside {OP_ADD_IMM, OP_AND_IMM};
      tomem = op inside {OP_ADC_MEM, OP_ADD_MEM, OP_AND_MEM};
      isand = op inside {OP_AND_WREG, OP_AND_IMM, OP_AND_MEM};
      // wrong source would be caught: the unused operand holds the complement
      u_mem.mem[8'h5A] = imm ? ~m : m;
      wr(`ADDR_WREG, {8'h00, w});
      wr(`ADDR_FLAGS, {12'h000, f});
      wr(`ADDR_PC, 16'h00FF);
      wr(`ADDR_OPERAND, {8'h00, imm ? m : ~m});
      wr(`ADDR_CMD, {8'h5A, 4'h0, op});
      wait_idle;
      r = add_ref(w, m, (op == OP_ADC_WREG || op == OP_ADC_MEM) ? f[0] : 1'b0);
      res = isand ? (w & m) : r[7:0];
      ef = isand ? {f[3], res == 8'h00, f[1:0]} : r[11:8];
      rd(`ADDR_WREG, v);
      chk(v, {8'h00, tomem ? w : res}, "wreg");
      rd(`ADDR_FLAGS, v);
      chk(v, {12'h000, ef}, "flags");
      chk({8'h00, u_mem.mem[8'h5A]}, {8'h00, tomem ? res : (imm ? ~m : m)}, "mem");
      rd(`ADDR_PC, v);
      chk(v, 16'h0100, "pc step");
      rd(`ADDR_STATUS, v);
      chk(v, {`SHORT_CYCLES, 8'h00}, "cycles short");
   endtask : do_op

   task automatic t_call(input logic [11:0] pc0, input logic [11:0] tgt);
      logic [15:0] v;
      int n;
      n = u_mem.push_cnt;
      wr(`ADDR_WREG, 16'h0033);
      wr(`ADDR_PC, {4'h0, pc0});
      wr(`ADDR_OPERAND, {4'h0, tgt});
      wr(`ADDR_CMD, {8'h00, 4'h0, OP_CALL});
      wr(`ADDR_WREG, 16'h00EE);
      wait_idle;
      chk({4'h0, pc_out}, {4'h0, tgt}, "call target");
      chk({4'h0, u_mem.stk_top}, {4'h0, pc0 + `PC_STEP}, "return addr");
      chk(16'(u_mem.push_cnt - n), 16'h0001, "push count");
      rd(`ADDR_STATUS, v);
      chk(v, {`CALL_CYCLES, 8'h00}, "call cycles");
      rd(`ADDR_WREG, v);
      chk(v, 16'h0033, "write while busy");
   endtask : t_call

   initial
   begin
      #100000;
      error_cnt++;
      $display("[ERR] %0t watchdog", $time);
      conclude();
   end

   initial
   begin
      repeat (2) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      t_reset();
      for (int i = 0; i < 8; i++)
      begin
         do_op(op_t'(i), 8'h7F, 8'h80, 4'h1);
         do_op(op_t'(i), 8'h88, 8'h88, 4'hA);
      end
      t_call(12'h123, 12'hABC);
      t_call(12'hFFF, 12'h001);
      conclude();
   end
endmodule : tb_top
